// file: rtl/pgls_pkg.sv
/*
 Shared constants, drive states and trigger mapping for the panel gate
 level shifter with gate voltage shaping.
 Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
// Overview of operation
// RULE1: Channels one to seven drive from high rail a, eight and nine from high rail b, all share the low rail.
// RULE2: Only channels one to six may ever enter the shaping state.
// RULE3: A rising channel input drives that output high with low driver and discharge off.
// RULE4: An accepted falling trigger edge on a high shaping channel stops the high drive and opens discharge.
// RULE5: A falling channel input closes discharge and drives that output low.
// RULE6: Every shaping channel runs high, shape, low on its own input pulses.
// RULE7: With one trigger in six-phase use, trigger one governs all six shaping channels.
// RULE8: With three triggers in six-phase use, triggers one, two, three govern channels 1/4, 2/5, 3/6.
// RULE9: In four-phase use, trigger one governs phases 1/3 and trigger two phases 2/4.
// RULE10: In four-phase use the outside ties inputs three and six high or to inputs two and five.
// RULE11: A falling trigger edge counts only in the last 60 degrees (six-phase) or 90 degrees (four-phase).
// RULE12: A falling trigger edge outside the window is ignored and the output keeps its state.
// RULE13: Rising trigger edges never have any effect.
// RULE14: Channels seven to nine follow their input level directly.
// RULE15: The window is the final part of the channel's own high time, sized from its measured period.
// RULE16: At most one shaping step happens per input high pulse.
package pgls_pkg;

   localparam int NUM_CH = 9;
   localparam int NUM_SHAPE = 6;
   localparam int NUM_RAIL_A = 7;
   localparam int NUM_TRIG = 3;
   localparam int NUM_MODE = 2;
   localparam int DEG_FULL = 360;
   localparam int DEG_WIN_SIX = 60;
   localparam int DEG_WIN_FOUR = 90;
   localparam int WIN_DIV_SIX = DEG_FULL / DEG_WIN_SIX;
   localparam int WIN_DIV_FOUR = DEG_FULL / DEG_WIN_FOUR;
   localparam int TRIG_ONE = 0;
   localparam int TRIG_TWO = 1;
   localparam int TRIG_THREE = 2;
   // Channel n and n+3 always share one trigger
   localparam int PHASE_GROUP = 3;

   typedef enum logic [1:0] {DRV_LOW, DRV_HIGH, DRV_SHAPE} pgls_drive_e;

   // Trigger that governs shaping channel ch (0 based)
   function automatic int pgls_trig_sel(int ch, logic six, logic single);
      if (six && single) begin
         return TRIG_ONE;
      end
      // Four-phase: third trigger is grounded, strapped lanes follow two
      if (!six && (ch % PHASE_GROUP) == TRIG_THREE) begin
         return TRIG_TWO;
      end
      return ch % PHASE_GROUP;
   endfunction

endpackage

// file: rtl/pgls_chan_if.sv
/*
 Per-channel link between the shaping control and one channel driver.
 Assumes the control side drives one-cycle edge strobes on clk.
*/
interface pgls_chan_if;
   logic level;
   logic rise;
   logic fall;
   logic accept;
   pgls_pkg::pgls_drive_e state;

   modport ctrl (output level, output rise, output fall, output accept,
                 input state);
   modport chan (input level, input rise, input fall, input accept,
                 output state);
endinterface

// file: rtl/pgls_sync.sv
/*
 Two-flop synchroniser for a bundle of pin inputs.
 Assumes each bit is an independent level; no bus coherency is kept.
*/
module pgls_sync import pgls_pkg::*; #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Pins in, clean levels out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } pgls_sync_s;

   pgls_sync_s st;
   pgls_sync_s next_st;

   always_comb begin
      next_st = st;
      next_st.meta = d;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.stable;
endmodule // pgls_sync

// file: rtl/pgls_chan.sv
/*
 One level shifter channel: drive-high, shaping and drive-low sequencing.
 Assumes one-cycle rise, fall and accept strobes from the control side.
*/
module pgls_chan import pgls_pkg::*; #(
   parameter bit SHAPE_EN = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Control link
   pgls_chan_if.chan ch
);
   typedef struct packed {
      pgls_drive_e state;
   } pgls_chan_s;

   pgls_chan_s st;
   pgls_chan_s next_st;

   always_comb begin
      next_st = st;
      if (!SHAPE_EN) begin
         next_st.state = ch.level ? DRV_HIGH : DRV_LOW; // RULE14 RULE2
      end else if (ch.rise) begin
         next_st.state = DRV_HIGH; // RULE3 RULE6
      end else if (ch.fall) begin
         next_st.state = DRV_LOW; // RULE5
      end else begin
         case (st.state)
            DRV_HIGH: begin
               // Shape state is left only by a fall, so one step per pulse
               if (ch.accept) begin
                  next_st.state = DRV_SHAPE; // RULE4 RULE16
               end
            end
            DRV_SHAPE: next_st.state = DRV_SHAPE;
            DRV_LOW: next_st.state = DRV_LOW;
            default: next_st.state = DRV_LOW;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '{state: DRV_LOW};
      end else begin
         st <= next_st;
      end
   end

   assign ch.state = st.state;
endmodule // pgls_chan

// file: rtl/pgls_level_shift.sv
/*
 Logic side of a nine-channel gate level shifter with gate voltage
 shaping on channels one to six, and flicker edge window checking.
 Assumes all pins are asynchronous to clk and the arrangement straps
 are held steady while channels toggle.
*/
module pgls_level_shift import pgls_pkg::*; #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Channel and shaping trigger pins
   input wire logic [NUM_CH-1:0] channel_input_n,
   input wire logic shaping_trigger_one,
   input wire logic shaping_trigger_two,
   input wire logic shaping_trigger_three,
   // Arrangement straps
   input wire logic six_phase_mode,
   input wire logic single_trigger_mode,
   // Output stage controls
   output logic [NUM_RAIL_A-1:0] gate_high_a,
   output logic [NUM_CH-NUM_RAIL_A-1:0] gate_high_b,
   output logic [NUM_CH-1:0] gate_low,
   output logic [NUM_SHAPE-1:0] shaping_discharge
);
   localparam int AW = CNT_W + 3;
   localparam int SW = NUM_CH + NUM_TRIG + NUM_MODE;

   // --------------------------------------------------------------
   // Parameter checks
   // --------------------------------------------------------------
   if (CNT_W < 4 || CNT_W > 28) begin : g_bad_width
      $error("CNT_W must lie between 4 and 28");
   end

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0] prev_in;
      logic [NUM_TRIG-1:0] prev_trig;
      logic [NUM_SHAPE-1:0][CNT_W-1:0] since_rise;
      logic [NUM_SHAPE-1:0][CNT_W-1:0] period;
      logic [NUM_SHAPE-1:0][CNT_W-1:0] high_len;
      logic [NUM_SHAPE-1:0] got_rise;
      logic [NUM_SHAPE-1:0] got_high;
      logic [NUM_SHAPE-1:0] ref_ok;
      logic [NUM_CH-1:0] drv_high;
      logic [NUM_CH-1:0] drv_low;
      logic [NUM_SHAPE-1:0] shape;
   } pgls_top_s;

   pgls_top_s st;
   pgls_top_s next_st;

   logic [SW-1:0] sy_all;
   logic [NUM_CH-1:0] sy_in;
   logic [NUM_TRIG-1:0] sy_trig;
   logic sy_six;
   logic sy_single;
   logic [NUM_CH-1:0] rise;
   logic [NUM_CH-1:0] fall;
   logic [NUM_TRIG-1:0] tfall;
   logic [NUM_SHAPE-1:0] win_ok;
   logic [NUM_SHAPE-1:0] accept;
   pgls_drive_e chan_state [NUM_CH];

   // --------------------------------------------------------------
   // Window check
   // --------------------------------------------------------------
   // Open when since + period/k >= high, k = 360/window degrees;
   // multiplied out so no divider is needed.
   function automatic logic win_open(logic [CNT_W-1:0] since,
                                     logic [CNT_W-1:0] per,
                                     logic [CNT_W-1:0] hi,
                                     logic six);
      logic [AW-1:0] k;
      logic [AW-1:0] lhs;
      logic [AW-1:0] rhs;
      k = six ? AW'(WIN_DIV_SIX) : AW'(WIN_DIV_FOUR); // RULE11
      lhs = AW'(since) * k + AW'(per);
      rhs = AW'(hi) * k;
      return lhs >= rhs; // RULE15
   endfunction

   function automatic logic [CNT_W-1:0] sat_inc(logic [CNT_W-1:0] v);
      return (v == '1) ? v : v + 1'b1;
   endfunction

   // --------------------------------------------------------------
   // Pin synchronisers and edge detect
   // --------------------------------------------------------------
   pgls_sync #(.W(SW)) u_sync (
      .clk(clk),
      .srst(srst),
      .d({single_trigger_mode, six_phase_mode, shaping_trigger_three,
          shaping_trigger_two, shaping_trigger_one, channel_input_n}),
      .q(sy_all)
   );

   assign sy_in = sy_all[NUM_CH-1:0];
   assign sy_trig = sy_all[NUM_CH+NUM_TRIG-1:NUM_CH];
   assign sy_six = sy_all[NUM_CH+NUM_TRIG];
   assign sy_single = sy_all[NUM_CH+NUM_TRIG+1];

   assign rise = sy_in & ~st.prev_in;
   assign fall = ~sy_in & st.prev_in;
   // Only falling trigger edges are looked at
   assign tfall = ~sy_trig & st.prev_trig; // RULE13

   // --------------------------------------------------------------
   // Channels
   // --------------------------------------------------------------
   pgls_chan_if ch_if [NUM_CH] ();

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      if (c < NUM_SHAPE) begin : g_shp
         assign win_ok[c] = st.ref_ok[c] &&
            win_open(st.since_rise[c], st.period[c], st.high_len[c],
                     sy_six);
         assign accept[c] = sy_in[c] && win_ok[c] &&
            tfall[pgls_trig_sel(c, sy_six, sy_single)]; // RULE7 RULE8 RULE9 RULE12
         assign ch_if[c].accept = accept[c];
      end else begin : g_plain
         assign ch_if[c].accept = 1'b0;
      end
      assign ch_if[c].level = sy_in[c];
      assign ch_if[c].rise = rise[c];
      assign ch_if[c].fall = fall[c];
      assign chan_state[c] = ch_if[c].state;

      pgls_chan #(.SHAPE_EN(c < NUM_SHAPE)) u_chan (
         .clk(clk),
         .srst(srst),
         .ch(ch_if[c])
      );
   end

   // --------------------------------------------------------------
   // Measurement and output registers
   // --------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.prev_in = sy_in;
      next_st.prev_trig = sy_trig;
      for (int i = 0; i < NUM_SHAPE; i++) begin
         if (rise[i]) begin
            next_st.since_rise[i] = '0;
            next_st.got_rise[i] = 1'b1;
            if (st.got_rise[i]) begin
               next_st.period[i] = sat_inc(st.since_rise[i]); // RULE15
               next_st.ref_ok[i] = st.got_high[i];
            end
         end else begin
            next_st.since_rise[i] = sat_inc(st.since_rise[i]);
         end
         if (fall[i] && st.got_rise[i]) begin
            next_st.high_len[i] = st.since_rise[i]; // RULE15
            next_st.got_high[i] = 1'b1;
         end
      end
      for (int c = 0; c < NUM_CH; c++) begin
         next_st.drv_high[c] = (chan_state[c] == DRV_HIGH);
         next_st.drv_low[c] = (chan_state[c] == DRV_LOW);
      end
      for (int i = 0; i < NUM_SHAPE; i++) begin
         next_st.shape[i] = (chan_state[i] == DRV_SHAPE);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         // Park every channel on the low driver, never all drivers off
         st <= '{drv_low: '1, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // Rail a feeds channels one to seven, rail b the last two
   assign gate_high_a = st.drv_high[NUM_RAIL_A-1:0]; // RULE1
   assign gate_high_b = st.drv_high[NUM_CH-1:NUM_RAIL_A]; // RULE1
   assign gate_low = st.drv_low;
   assign shaping_discharge = st.shape;

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   a_rail_b_split: assert property ( // RULE1
      ##1 gate_high_b == {$past(chan_state[NUM_CH-1] == DRV_HIGH),
                          $past(chan_state[NUM_RAIL_A] == DRV_HIGH)})
      else $error("rail b outputs do not follow channels eight and nine");

   a_late_no_shape: assert property ( // RULE2
      chan_state[6] != DRV_SHAPE && chan_state[7] != DRV_SHAPE &&
      chan_state[8] != DRV_SHAPE)
      else $error("non-shaping channel entered shaping");

   for (genvar i = 0; i < NUM_SHAPE; i++) begin : g_chk
      sequence s_out_high;
         st.drv_high[i] && !st.drv_low[i] && !st.shape[i];
      endsequence
      sequence s_out_shape;
         !st.drv_high[i] && !st.drv_low[i] && st.shape[i];
      endsequence
      sequence s_out_low;
         !st.drv_high[i] && st.drv_low[i] && !st.shape[i];
      endsequence

      a_rise_drive_high: assert property ( // RULE3
         rise[i] |=> chan_state[i] == DRV_HIGH ##1 s_out_high)
         else $error("rising input did not drive high");

      a_accept_shape: assert property ( // RULE4
         accept[i] && chan_state[i] == DRV_HIGH && !fall[i]
         |=> chan_state[i] == DRV_SHAPE ##1 s_out_shape)
         else $error("accepted trigger edge did not start shaping");

      a_fall_drive_low: assert property ( // RULE5
         fall[i] |=> chan_state[i] == DRV_LOW ##1 s_out_low)
         else $error("falling input did not drive low");

      a_shape_cause: assert property ( // RULE6
         $rose(chan_state[i] == DRV_SHAPE) |-> $past(accept[i]))
         else $error("shaping began without an accepted edge");

      a_trig_map: assert property ( // RULE7 RULE8 RULE9
         accept[i] |-> (sy_six && sy_single) ? tfall[TRIG_ONE] :
            (!sy_six && i % PHASE_GROUP == TRIG_THREE) ? tfall[TRIG_TWO] :
            tfall[i % PHASE_GROUP])
         else $error("shaping edge taken from the wrong trigger");

      a_window_gate: assert property ( // RULE11 RULE12
         chan_state[i] == DRV_HIGH && !win_ok[i] && !rise[i] && !fall[i]
         |=> chan_state[i] == DRV_HIGH)
         else $error("trigger edge outside the window had effect");

      a_trig_rise_none: assert property ( // RULE13
         chan_state[i] == DRV_HIGH && $rose(sy_trig[TRIG_ONE]) &&
         !tfall[TRIG_TWO] && !tfall[TRIG_THREE] && !fall[i] && !rise[i]
         |=> chan_state[i] == DRV_HIGH)
         else $error("rising trigger edge had effect");

      a_ref_needed: assert property ( // RULE15
         accept[i] |-> st.ref_ok[i] && sy_in[i])
         else $error("edge accepted without a measured reference");

      a_shape_holds: assert property ( // RULE16
         chan_state[i] == DRV_SHAPE && !fall[i] && !rise[i]
         |=> chan_state[i] == DRV_SHAPE [*1] ##1 !st.drv_high[i])
         else $error("second shaping step within one pulse");

      a_shape_from_high: assert property ( // RULE4
         $rose(chan_state[i] == DRV_SHAPE) |-> $past(chan_state[i]) == DRV_HIGH)
         else $error("shaping entered from a state other than high");

      a_accept_in_win: assert property ( // RULE11
         accept[i] |-> win_ok[i])
         else $error("trigger edge accepted outside the window");

      a_low_ignores: assert property ( // RULE12
         chan_state[i] == DRV_LOW && !rise[i] |=> chan_state[i] == DRV_LOW)
         else $error("low channel left low without a rising input");
   end

   for (genvar c = NUM_SHAPE; c < NUM_CH; c++) begin : g_lvl
      a_level_follow: assert property ( // RULE14
         sy_in[c] |=> chan_state[c] == DRV_HIGH ##1 st.drv_high[c])
         else $error("plain channel did not follow its input");
      a_level_low: assert property ( // RULE14
         !sy_in[c] |=> chan_state[c] == DRV_LOW ##1 st.drv_low[c])
         else $error("plain channel did not go low with its input");
   end

   // Output stage per channel, shaping lanes padded for the plain ones
   logic [NUM_CH-1:0] out_high;
   logic [NUM_CH-1:0] out_shape;
   assign out_high = {gate_high_b, gate_high_a};
   assign out_shape = {{(NUM_CH-NUM_SHAPE){1'b0}}, shaping_discharge};

   // Checked through reset too: a floating gate line is the real hazard
   a_reset_low: assert property ( // RULE5
      disable iff (1'b0)
      srst |=> gate_low == '1 && out_high == '0 && out_shape == '0)
      else $error("reset did not park every channel low");

   for (genvar c = 0; c < NUM_CH; c++) begin : g_excl
      a_one_driver: assert property ( // RULE3 RULE4 RULE5
         $onehot({out_high[c], out_shape[c], gate_low[c]}))
         else $error("channel output stage not in exactly one state");
   end

endmodule // pgls_level_shift

// file: dv/pgls_tcon_model.sv
/*
 Timing controller model: drives channel pins, shaping triggers and
 arrangement straps of the level shifter through tasks.
 Assumes the bench calls its tasks just after a rising edge of clk.
*/
module pgls_tcon_model import pgls_pkg::*; (
   // Clock
   input wire logic clk,
   // Pins towards the level shifter
   output logic [NUM_CH-1:0] chan,
   output logic [NUM_TRIG-1:0] trig,
   output logic six,
   output logic single
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      chan = '0;
      trig = '0;
      six = 1'b0;
      single = 1'b0;
   end

   // Same small delay after the last edge keeps pin changes off the edge
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // ----------------------------------------
   // Arrangement setup
   // ----------------------------------------
   task automatic set_mode(logic s6, logic s1);
      six = s6;
      single = s1;
      trig[TRIG_ONE] = 1'b1;
      trig[TRIG_TWO] = !(s6 && s1);
      trig[TRIG_THREE] = s6 && !s1;
      chan[2] = !s6;
      chan[5] = !s6;
      tick(12);
   endtask

   // ----------------------------------------
   // One channel pulse, split round the checks
   // ----------------------------------------
   // Two falls of trigger tg from cycle tf, four cycles apart; a rise two cycles after each
   task automatic pulse_high(int c, int tg, int tf, logic [2:0] lv);
      chan[c] = 1'b1;
      chan[8:6] = lv;
      if (tg < 0) begin
         tick(27);
      end else begin
         tick(tf);
         repeat (2) begin
            trig[tg] = 1'b0;
            tick(2);
            trig[tg] = 1'b1;
            tick(2);
         end
         tick(27 - tf - 8);
      end
   endtask

   task automatic pulse_low(int c, logic [2:0] lv);
      chan[c] = 1'b0;
      chan[8:6] = lv;
      tick(6);
   endtask
endmodule // pgls_tcon_model

// file: dv/tb_pgls_level_shift.sv
/*
 Self-checking bench for the gate level shifter: per-channel pulses in
 every trigger arrangement, in and out of the shaping window.
 Assumes the design reacts within five edges of a pin change.
*/
`define CHK(got, want) begin num_checks++; if ((got) !== (want)) begin \
   failures++; $display("BAD t=%0t got %b want %b", $time, got, want); \
   end end

module tb_pgls_level_shift import pgls_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic srst;
   logic [NUM_CH-1:0] chan;
   logic [NUM_TRIG-1:0] trig;
   logic six;
   logic single;
   logic [NUM_RAIL_A-1:0] gate_high_a;
   logic [NUM_CH-NUM_RAIL_A-1:0] gate_high_b;
   logic [NUM_CH-1:0] gate_low;
   logic [NUM_SHAPE-1:0] shaping_discharge;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   pgls_drive_e exp_st [NUM_CH];

   always #12.5 clk = ~clk;

   pgls_tcon_model model (
      .clk(clk),
      .chan(chan),
      .trig(trig),
      .six(six),
      .single(single)
   );

   pgls_level_shift dut_u (
      .clk(clk),
      .srst(srst),
      .channel_input_n(chan),
      .shaping_trigger_one(trig[0]),
      .shaping_trigger_two(trig[1]),
      .shaping_trigger_three(trig[2]),
      .six_phase_mode(six),
      .single_trigger_mode(single),
      .gate_high_a(gate_high_a),
      .gate_high_b(gate_high_b),
      .gate_low(gate_low),
      .shaping_discharge(shaping_discharge)
   );

   task automatic summarize();
      if (failures == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Run needs about 3200 cycles; ceiling leaves ample margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end

   // ----------------------------------------
   // Expectations
   // ----------------------------------------
   function automatic logic [2:0] enc(pgls_drive_e s);
      case (s)
         DRV_HIGH: return 3'h4;
         DRV_SHAPE: return 3'h2;
         default: return 3'h1;
      endcase
   endfunction

   // Trigger that should govern shaping channel c (0 based)
   function automatic int gov(int c, logic s6, logic s1);
      if (s1) begin
         return 0;
      end
      if (s6) begin
         return c % 3;
      end
      return (c % 3 == 0) ? 0 : 1;
   endfunction

   task automatic set_lv(logic [2:0] lv);
      for (int i = 0; i < 3; i++) begin
         exp_st[6 + i] = lv[i] ? DRV_HIGH : DRV_LOW;
      end
   endtask

   // Every channel checked so a pulse on one disturbing another shows
   task automatic chk_all();
      logic [NUM_CH-1:0] hi;
      logic [NUM_CH-1:0] sh;
      logic [2:0] got;
      hi = {gate_high_b, gate_high_a};
      sh = {3'h0, shaping_discharge};
      for (int i = 0; i < NUM_CH; i++) begin
         got = {hi[i], sh[i], gate_low[i]};
         `CHK(got, enc(exp_st[i]))
      end
   endtask

   task automatic run_pulse(int c, int tg, int tf, bit shp);
      logic [2:0] lv;
      lv = 3'($urandom);
      model.pulse_high(c, tg, tf, lv);
      exp_st[c] = shp ? DRV_SHAPE : DRV_HIGH;
      set_lv(lv);
      chk_all();
      lv = 3'($urandom);
      model.pulse_low(c, lv);
      exp_st[c] = DRV_LOW;
      set_lv(lv);
      chk_all();
      model.tick(22);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic s6;
      logic s1;
      int g;
      int w;
      srst = 1'b1;
      void'($urandom(32'h72be_9394));
      foreach (exp_st[i]) exp_st[i] = DRV_LOW;
      repeat (6) @(posedge clk);
      #2;
      srst = 1'b0;
      model.tick(3);
      chk_all();
      // Four-phase first, while the strapped lanes have no history
      for (int m = 0; m < 3; m++) begin
         s6 = (m != 0);
         s1 = (m == 2);
         model.set_mode(s6, s1);
         exp_st[2] = s6 ? DRV_LOW : DRV_HIGH;
         exp_st[5] = exp_st[2];
         chk_all();
         for (int c = 0; c < NUM_SHAPE; c++) begin
            if (s6 || (c % 3 != 2)) begin
               g = gov(c, s6, s1);
               w = s6 ? (c + 1) % 3 : 1 - g;
               run_pulse(c, -1, 0, 1'b0);
               if (!s1) run_pulse(c, w, 20, 1'b0);
               run_pulse(c, g, 5, 1'b0);
               run_pulse(c, g, 20, 1'b1);
            end
         end
      end
      summarize();
   end
endmodule // tb_pgls_level_shift
